// File: logic/drive_interface.sv
module drive_interface #(
	parameter int unsigned index_min_cycles = drive_pkg::INDEX_MIN_CYCLES,
	parameter int unsigned index_max_cycles = drive_pkg::INDEX_MAX_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// unit-select straps
	input wire logic unit_strap_zero,
	input wire logic unit_strap_one,
	input wire logic unit_strap_two,
	input wire logic unit_strap_three,
	// ready strap and control card variant
	input wire logic ready_strap,
	input wire logic dynamic_card,
	// motor straps
	input wire logic motor_strap_a,
	input wire logic motor_strap_b,
	input wire logic motor_strap_c,
	input wire logic motor_strap_d,
	// host unit-select lines, active low
	input wire logic unit_select0_n,
	input wire logic unit_select1_n,
	input wire logic unit_select2_n,
	// shared line: fourth select in, ready out
	input wire logic shared_line_in,
	output logic shared_line_out,
	output logic shared_line_oe,
	// host motor command, active low
	input wire logic motor_on_n,
	// drive status
	input wire logic power_good,
	input wire logic index_pulse,
	// dedicated ready line, active low
	output logic dedicated_ready_n,
	// motors and select indicator
	output logic spindle_on,
	output logic stepper_on,
	output logic drive_selected
);
	import drive_pkg::*;

	logic [NUM_UNITS-1:0] unit_straps; // strap vector
	logic [NUM_UNITS-1:0] select_req; // active-high select requests
	logic motor_cmd; // active-high motor command
	logic sel_hit; // registered select match
	logic period_ok; // index repetition acceptable
	motor_mode_type motor_mode; // decoded strap combination
	logic ready_level; // ready condition for this card
	logic nxt_spindle;
	logic nxt_stepper;
	logic nxt_shared_oe;
	logic nxt_ready_n;

	// registered outputs
	logic drive_selected_ff;
	logic spindle_on_ff;
	logic stepper_on_ff;
	logic shared_line_oe_ff;
	logic shared_line_out_ff;
	logic dedicated_ready_n_ff;

	// strap combination decode; anything unlisted leaves motors off
	function automatic motor_mode_type decode_motor(input logic a, input logic b, input logic c, input logic d);
		motor_mode_type m;
		m = MODE_NONE;
		case ({a, b, c, d})
			4'h9: m = MODE_CMD_SEL; // A and D
			4'ha: m = MODE_CMD_BOTH; // A and C
			4'h6: m = MODE_SEL_BOTH; // B and C
			4'h8: m = MODE_CMD_POWER; // A alone
			4'h4: m = MODE_SEL_POWER; // B alone
			default: m = MODE_NONE; // illegal or empty fitting
		endcase
		return m;
	endfunction

	assign unit_straps = {unit_strap_three, unit_strap_two, unit_strap_one, unit_strap_zero};
	// low on an asterisk line means active
	assign select_req = {shared_line_in == LINE_ACTIVE, unit_select2_n == LINE_ACTIVE,
		unit_select1_n == LINE_ACTIVE, unit_select0_n == LINE_ACTIVE};
	assign motor_cmd = (motor_on_n == LINE_ACTIVE);
	assign motor_mode = decode_motor(motor_strap_a, motor_strap_b, motor_strap_c, motor_strap_d);

	// select line match, one register stage
	select_match u_select (
		.clock(clock),
		.reset_n(reset_n),
		.unit_straps(unit_straps),
		.ready_strap(ready_strap),
		.select_req(select_req),
		.hit_ff(sel_hit)
	);

	// index period measurement, only meaningful with power
	index_period_check #(
		.CNT_W(INDEX_CNT_W),
		.MIN_CYCLES(INDEX_CNT_W'(index_min_cycles)),
		.MAX_CYCLES(INDEX_CNT_W'(index_max_cycles))
	) u_index (
		.clock(clock),
		.reset_n(reset_n),
		.enable(power_good),
		.index_pulse(index_pulse),
		.period_ok_ff(period_ok)
	);

	// static card: ready follows select; dynamic card also needs power and spin
	assign ready_level = dynamic_card ? (sel_hit && power_good && period_ok) : sel_hit;

	// the shared line is only driven when the ready strap hands it over
	assign nxt_shared_oe = ready_strap && ready_level;
	// the static card has no dedicated ready driver
	assign nxt_ready_n = (dynamic_card && ready_level) ? LINE_ACTIVE : LINE_IDLE;

	// spindle source per strap combination; power is always required
	always_comb
	begin
		nxt_spindle = 1'b0;
		nxt_stepper = 1'b0;
		case (motor_mode)
			MODE_CMD_SEL:
			begin
				nxt_spindle = motor_cmd;
				nxt_stepper = sel_hit;
			end
			MODE_CMD_BOTH:
			begin
				nxt_spindle = motor_cmd;
				nxt_stepper = motor_cmd;
			end
			MODE_SEL_BOTH:
			begin
				nxt_spindle = sel_hit;
				nxt_stepper = sel_hit;
			end
			MODE_CMD_POWER:
			begin
				nxt_spindle = motor_cmd;
				nxt_stepper = 1'b1;
			end
			MODE_SEL_POWER:
			begin
				nxt_spindle = sel_hit;
				nxt_stepper = 1'b1;
			end
			default:
			begin
				// illegal fitting: keep both motors still rather than guess
				nxt_spindle = 1'b0;
				nxt_stepper = 1'b0;
			end
		endcase
	end

	// output registers; the open-collector data bit only ever pulls low
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			drive_selected_ff <= 1'b0;
			spindle_on_ff <= 1'b0;
			stepper_on_ff <= 1'b0;
			shared_line_oe_ff <= 1'b0;
			shared_line_out_ff <= LINE_ACTIVE;
			dedicated_ready_n_ff <= LINE_IDLE;
		end
		else
		begin
			drive_selected_ff <= sel_hit;
			spindle_on_ff <= nxt_spindle && power_good;
			stepper_on_ff <= nxt_stepper && power_good;
			shared_line_oe_ff <= nxt_shared_oe;
			shared_line_out_ff <= LINE_ACTIVE;
			dedicated_ready_n_ff <= nxt_ready_n;
		end
	end

	assign drive_selected = drive_selected_ff;
	assign spindle_on = spindle_on_ff;
	assign stepper_on = stepper_on_ff;
	assign shared_line_oe = shared_line_oe_ff;
	assign shared_line_out = shared_line_out_ff;
	assign dedicated_ready_n = dedicated_ready_n_ff;

	// checks on the select path, ready lines and motor straps
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// a strapped, usable line held active for two cycles
	sequence s_strap_request;
		(unit_strap_zero && !unit_select0_n) [*2];
	endsequence

	sequence s_selected_settle;
		##1 drive_selected_ff;
	endsequence

	property p_strapped_selects;
		s_strap_request |-> s_selected_settle;
	endproperty
	a_strapped_selects: assert property (p_strapped_selects) else $error("strapped line did not select");

	property p_unstrapped_ignored;
		(!unit_strap_zero && unit_strap_one && !unit_strap_two && !unit_strap_three
			&& unit_select1_n && unit_select2_n && shared_line_in) [*2] |=> !drive_selected_ff;
	endproperty
	a_unstrapped_ignored: assert property (p_unstrapped_ignored) else $error("unstrapped line selected drive");

	property p_delivered_unit_zero;
		(unit_straps == UNIT_STRAPS_NONE && !unit_select0_n) [*2] |=> drive_selected_ff;
	endproperty
	a_delivered_unit_zero: assert property (p_delivered_unit_zero) else $error("no strap should mean unit zero");

	property p_shared_select_blocked;
		(ready_strap && unit_straps == 4'h8 && unit_select0_n && unit_select1_n && unit_select2_n) [*2]
			|=> !drive_selected_ff;
	endproperty
	a_shared_select_blocked: assert property (p_shared_select_blocked) else $error("fourth select with ready strap");

	property p_static_ready;
		(sel_hit && ready_strap && !dynamic_card) |=> (shared_line_oe_ff && shared_line_out_ff == LINE_ACTIVE);
	endproperty
	a_static_ready: assert property (p_static_ready) else $error("static ready missing on shared line");

	property p_dynamic_ready_cause;
		(dedicated_ready_n_ff == LINE_ACTIVE) |-> $past(sel_hit && power_good && period_ok && dynamic_card);
	endproperty
	a_dynamic_ready_cause: assert property (p_dynamic_ready_cause) else $error("dynamic ready without cause");

	property p_unselected_quiet;
		!sel_hit |=> (!shared_line_oe_ff && dedicated_ready_n_ff == LINE_IDLE);
	endproperty
	a_unselected_quiet: assert property (p_unselected_quiet) else $error("outputs active while unselected");

	property p_cmd_sel_mode;
		(motor_mode == MODE_CMD_SEL && power_good) |=> (spindle_on_ff == $past(motor_cmd) && stepper_on_ff == $past(sel_hit));
	endproperty
	a_cmd_sel_mode: assert property (p_cmd_sel_mode) else $error("A and D motor behaviour wrong");

	property p_cmd_both_mode;
		(motor_mode == MODE_CMD_BOTH && power_good && !motor_on_n) |=> (spindle_on_ff && stepper_on_ff);
	endproperty
	a_cmd_both_mode: assert property (p_cmd_both_mode) else $error("A and C motor behaviour wrong");

	property p_sel_both_mode;
		(motor_mode == MODE_SEL_BOTH && power_good) |=> (spindle_on_ff == $past(sel_hit) && stepper_on_ff == $past(sel_hit));
	endproperty
	a_sel_both_mode: assert property (p_sel_both_mode) else $error("B and C motor behaviour wrong");

	property p_power_stepper;
		((motor_mode == MODE_CMD_POWER || motor_mode == MODE_SEL_POWER) && power_good) |=> stepper_on_ff;
	endproperty
	a_power_stepper: assert property (p_power_stepper) else $error("stepper not held by power");

	property p_sel_power_spindle;
		(motor_mode == MODE_SEL_POWER && power_good && motor_cmd && !sel_hit) |=> !spindle_on_ff;
	endproperty
	a_sel_power_spindle: assert property (p_sel_power_spindle) else $error("B alone spindle follows command");

	// later card with the strap: ready must appear on both lines together
	property p_dynamic_both_lines;
		(sel_hit && power_good && period_ok && dynamic_card && ready_strap)
			|=> (dedicated_ready_n_ff == LINE_ACTIVE && shared_line_oe_ff);
	endproperty
	a_dynamic_both_lines: assert property (p_dynamic_both_lines) else $error("dynamic ready missing on a line");

	// the static card never pulls the dedicated line
	property p_static_no_dedicated;
		!dynamic_card |=> (dedicated_ready_n_ff == LINE_IDLE);
	endproperty
	a_static_no_dedicated: assert property (p_static_no_dedicated) else $error("static card drove dedicated ready");

	// without the ready strap the shared wire belongs to the host
	property p_shared_needs_strap;
		!ready_strap |=> !shared_line_oe_ff;
	endproperty
	a_shared_needs_strap: assert property (p_shared_needs_strap) else $error("shared line pulled without strap");

	// the indicator trails the internal match by one stage
	property p_indicator_follows;
		1'b1 |=> (drive_selected_ff == $past(sel_hit));
	endproperty
	a_indicator_follows: assert property (p_indicator_follows) else $error("select indicator out of step");

	// an unlisted fitting keeps both motors still
	property p_illegal_fit_still;
		(motor_mode == MODE_NONE) |=> (!spindle_on_ff && !stepper_on_ff);
	endproperty
	a_illegal_fit_still: assert property (p_illegal_fit_still) else $error("motor ran on unlisted fitting");

	// no motor runs without power, whatever the straps
	property p_motors_need_power;
		!power_good |=> (!spindle_on_ff && !stepper_on_ff);
	endproperty
	a_motors_need_power: assert property (p_motors_need_power) else $error("motor on without power");
endmodule

// File: logic/drive_pkg.sv
package drive_pkg;
	// clock and time base
	localparam longint unsigned CLOCK_HZ = 64'd20_000_000;
	localparam longint unsigned MS_PER_S = 64'd1000;
	// index repetition window in milliseconds
	localparam longint unsigned INDEX_MIN_MS = 64'd200;
	localparam longint unsigned INDEX_MAX_MS = 64'd300;
	// least period rounds up, longest rounds down
	localparam int unsigned INDEX_MIN_CYCLES = int'((INDEX_MIN_MS * CLOCK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
	localparam int unsigned INDEX_MAX_CYCLES = int'((INDEX_MAX_MS * CLOCK_HZ) / MS_PER_S);
	// counter width, with headroom for one saturating step
	localparam int INDEX_CNT_W = $clog2(INDEX_MAX_CYCLES + 2);
	// unit-select lines and straps
	localparam int NUM_UNITS = 4;
	localparam int SHARED_UNIT = 3;
	localparam logic [NUM_UNITS-1:0] UNIT_STRAPS_DELIVERED = 4'h1;
	localparam logic [NUM_UNITS-1:0] UNIT_STRAPS_NONE = 4'h0;
	// line levels: interface lines are open collector, low is active
	localparam logic LINE_ACTIVE = 1'h0;
	localparam logic LINE_IDLE = 1'h1;
	// motor strap combinations, one-hot
	typedef enum logic [5:0] {
		MODE_NONE = 6'h01,
		MODE_CMD_SEL = 6'h02,
		MODE_CMD_BOTH = 6'h04,
		MODE_SEL_BOTH = 6'h08,
		MODE_CMD_POWER = 6'h10,
		MODE_SEL_POWER = 6'h20
	} motor_mode_type;
endpackage

// File: logic/select_match.sv
module select_match (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// straps
	input wire logic [drive_pkg::NUM_UNITS-1:0] unit_straps,
	input wire logic ready_strap,
	// active-high select requests, already inverted
	input wire logic [drive_pkg::NUM_UNITS-1:0] select_req,
	// registered match
	output logic hit_ff
);
	import drive_pkg::*;

	logic [NUM_UNITS-1:0] eff_straps; // straps in force
	logic [NUM_UNITS-1:0] usable; // lines that may select
	logic [NUM_UNITS-1:0] line_hit; // per-line match
	logic nxt_hit;

	// no jumper at all behaves as the factory jumper on unit zero
	assign eff_straps = (unit_straps == UNIT_STRAPS_NONE) ? UNIT_STRAPS_DELIVERED : unit_straps;

	genvar i;
	generate
		for (i = 0; i < NUM_UNITS; i++)
		begin : g_line
			// shared line is lost to the ready option when that strap is in
			assign usable[i] = (i == SHARED_UNIT) ? !ready_strap : 1'b1;
			assign line_hit[i] = eff_straps[i] && usable[i] && select_req[i];
		end
	endgenerate

	assign nxt_hit = |line_hit;

	// one register stage, matches the other interface timing
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			hit_ff <= 1'b0;
		else
			hit_ff <= nxt_hit;
	end
endmodule

// File: logic/index_period_check.sv
module index_period_check #(
	parameter int CNT_W = drive_pkg::INDEX_CNT_W,
	parameter logic [CNT_W-1:0] MIN_CYCLES = CNT_W'(drive_pkg::INDEX_MIN_CYCLES),
	parameter logic [CNT_W-1:0] MAX_CYCLES = CNT_W'(drive_pkg::INDEX_MAX_CYCLES)
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// power present enables the measurement
	input wire logic enable,
	// active-high index pulse from the sensor
	input wire logic index_pulse,
	// last period was inside the window and none is overdue
	output logic period_ok_ff
);
	import drive_pkg::*;

	logic index_prev_ff; // previous index level
	logic [CNT_W-1:0] count_ff; // cycles since last index edge
	logic [CNT_W-1:0] nxt_count;
	logic nxt_ok;
	logic index_edge; // rising index edge
	logic overdue; // no index within the longest period
	logic in_window; // measured period acceptable

	assign index_edge = index_pulse && !index_prev_ff;
	assign overdue = count_ff > MAX_CYCLES;
	assign in_window = (count_ff >= MIN_CYCLES) && !overdue;
	// restart at one so the count seen at the next edge equals the period in cycles
	// saturate so a stopped spindle cannot wrap back into the window
	assign nxt_count = index_edge ? CNT_W'(1) : (overdue ? count_ff : count_ff + CNT_W'(1));
	// judged at each edge, dropped as soon as a pulse is overdue
	assign nxt_ok = index_edge ? in_window : (period_ok_ff && !overdue);

	// counter and verdict, cleared while power is absent
	always_ff @(posedge clock)
	begin
		if (!reset_n || !enable)
		begin
			index_prev_ff <= 1'b0;
			count_ff <= '0;
			period_ok_ff <= 1'b0;
		end
		else
		begin
			index_prev_ff <= index_pulse;
			count_ff <= nxt_count;
			period_ok_ff <= nxt_ok;
		end
	end
endmodule

// File: testbench/host_model.sv
module host_model (
	// clock
	input wire logic clock,
	// requests from the bench
	input wire logic [2:0] sel_unit,
	input wire logic motor_cmd,
	input wire logic [7:0] index_period,
	// lines from the drive
	input wire logic ready_strap,
	input wire logic shared_line_out,
	input wire logic shared_line_oe,
	input wire logic dedicated_ready_n,
	// lines to the drive
	output logic unit_select0_n,
	output logic unit_select1_n,
	output logic unit_select2_n,
	output logic shared_line_in,
	output logic motor_on_n,
	output logic index_pulse,
	// ready as the host sees it
	output logic host_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// index position counter, zero gives a pulse
	logic [7:0] index_cnt_ff = 8'h00;
	// selects are active low, unit 4 means none
	assign unit_select0_n = !(sel_unit == 3'h0);
	assign unit_select1_n = !(sel_unit == 3'h1);
	assign unit_select2_n = !(sel_unit == 3'h2);
	// open collector wire with pull-up: either party may pull it low
	assign shared_line_in = !((shared_line_oe && !shared_line_out) || (sel_unit == 3'h3));
	assign motor_on_n = !motor_cmd;
	// host issues no read or write here, so the motor start wait is never cut short
	// one-cycle pulse every index_period cycles, none when period is zero
	assign index_pulse = (index_period != 8'h00) && (index_cnt_ff == 8'h00);
	// only one ready line is used, chosen by how the strap is fitted
	assign host_ready = ready_strap ? !shared_line_in : !dedicated_ready_n;
	// counter moves off the sampling edge, like the bench
	always @(negedge clock)
	begin
		if (index_cnt_ff + 8'h01 >= index_period)
			index_cnt_ff <= 8'h00;
		else
			index_cnt_ff <= index_cnt_ff + 8'h01;
	end
endmodule

// File: testbench/drive_interface_bench.sv
module drive_interface_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// clock and reset
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	// straps as one nibble each, three down to zero and a..d
	logic [3:0] unit_straps = 4'h1;
	logic [3:0] motor_straps = 4'h0;
	logic ready_strap = 1'b0;
	logic dynamic_card = 1'b0;
	logic power_good = 1'b1;
	// host model requests
	logic [2:0] sel_unit = 3'h4;
	logic motor_cmd = 1'b0;
	logic [7:0] index_period = 8'h00;
	// wires between drive and host
	logic unit_select0_n, unit_select1_n, unit_select2_n, shared_line_in, shared_line_out;
	logic shared_line_oe, motor_on_n, index_pulse, dedicated_ready_n, host_ready;
	logic spindle_on, stepper_on, drive_selected;
	int fails = 0;
	int tests_run = 0;
	logic [3:0] modes [6] = '{4'h9, 4'ha, 4'h6, 4'h8, 4'h4, 4'hc};
	// window end points and one cycle past each, in and out by turns
	logic [7:0] periods [4] = '{8'h14, 8'h1f, 8'h1e, 8'h13};
	logic exp_sp, exp_st, c, s;

	// 20 MHz clock
	always #25 clock = !clock;

	drive_interface #(.index_min_cycles(20), .index_max_cycles(30)) i_drive_interface (
		.clock(clock), .reset_n(reset_n),
		.unit_strap_zero(unit_straps[0]), .unit_strap_one(unit_straps[1]),
		.unit_strap_two(unit_straps[2]), .unit_strap_three(unit_straps[3]),
		.ready_strap(ready_strap), .dynamic_card(dynamic_card),
		.motor_strap_a(motor_straps[3]), .motor_strap_b(motor_straps[2]),
		.motor_strap_c(motor_straps[1]), .motor_strap_d(motor_straps[0]),
		.unit_select0_n(unit_select0_n), .unit_select1_n(unit_select1_n), .unit_select2_n(unit_select2_n),
		.shared_line_in(shared_line_in), .shared_line_out(shared_line_out), .shared_line_oe(shared_line_oe),
		.motor_on_n(motor_on_n), .power_good(power_good), .index_pulse(index_pulse),
		.dedicated_ready_n(dedicated_ready_n), .spindle_on(spindle_on), .stepper_on(stepper_on),
		.drive_selected(drive_selected));

	host_model i_host_model (
		.clock(clock), .sel_unit(sel_unit), .motor_cmd(motor_cmd), .index_period(index_period),
		.ready_strap(ready_strap), .shared_line_out(shared_line_out), .shared_line_oe(shared_line_oe),
		.dedicated_ready_n(dedicated_ready_n), .unit_select0_n(unit_select0_n),
		.unit_select1_n(unit_select1_n), .unit_select2_n(unit_select2_n), .shared_line_in(shared_line_in),
		.motor_on_n(motor_on_n), .index_pulse(index_pulse), .host_ready(host_ready));

	// one comparison, counted
	task automatic check(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s is %b, wanted %b", $time, what, got, exp);
		end
	endtask

	// host request at the falling edge, then two rising edges of latency and one spare
	task automatic go(input logic [2:0] unit, input logic cmd);
		@(negedge clock);
		sel_unit = unit;
		motor_cmd = cmd;
		repeat (3) @(negedge clock);
	endtask

	// bounded wait for the dedicated ready line to go active
	task automatic wait_ready();
		int n;
		for (n = 0; n < 300 && dedicated_ready_n !== 1'b0; n++)
			@(negedge clock);
		if (n == 300)
		begin
			fails++;
			$display("unexpected at %0t: ready never came", $time);
			complete_run();
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		// reset for 20 cycles, outputs idle meanwhile
		repeat (20) @(negedge clock);
		check(drive_selected, 1'b0, "selected in reset");
		check(shared_line_oe, 1'b0, "shared oe in reset");
		check(dedicated_ready_n, 1'b1, "ready in reset");
		reset_n = 1'b1;
		$display("test reset done");
		// every strap against every select line, plus none
		for (int st = 0; st < 4; st++)
		begin
			unit_straps = 4'h1 << st;
			for (int u = 0; u < 5; u++)
			begin
				go(3'(u), 1'b0);
				check(drive_selected, 1'(st == u), "select match");
			end
		end
		unit_straps = 4'h0;
		go(3'h0, 1'b0);
		check(drive_selected, 1'b1, "no strap answers unit zero");
		go(3'h1, 1'b0);
		check(drive_selected, 1'b0, "no strap ignores unit one");
		// fourth select is lost once the ready strap takes the wire
		unit_straps = 4'h8;
		ready_strap = 1'b1;
		go(3'h3, 1'b0);
		check(drive_selected, 1'b0, "fourth select with ready strap");
		$display("test select done");
		// static card ready on the shared line
		unit_straps = 4'h1;
		go(3'h0, 1'b0);
		check(shared_line_oe, 1'b1, "static ready drive");
		check(shared_line_out, 1'b0, "static ready level");
		check(dedicated_ready_n, 1'b1, "static card dedicated line");
		go(3'h4, 1'b0);
		check(shared_line_oe, 1'b0, "static ready unselected");
		$display("test static ready done");
		// dynamic card: in-window, too fast and too slow index periods
		dynamic_card = 1'b1;
		for (int p = 0; p < 4; p++)
		begin
			index_period = periods[p];
			go(3'h0, 1'b0);
			repeat (150) @(negedge clock);
			check(dedicated_ready_n, 1'(p % 2), "dynamic ready by period");
			check(shared_line_oe, 1'(p % 2 == 0), "dynamic ready on shared line");
			check(host_ready, 1'(p % 2 == 0), "host view of ready");
		end
		index_period = 8'h19;
		wait_ready();
		go(3'h4, 1'b0);
		check(dedicated_ready_n, 1'b1, "dynamic ready unselected");
		go(3'h0, 1'b0);
		wait_ready();
		@(negedge clock);
		motor_straps = 4'h8;
		power_good = 1'b0;
		go(3'h0, 1'b0);
		check(dedicated_ready_n, 1'b1, "dynamic ready without power");
		check(stepper_on, 1'b0, "stepper without power");
		power_good = 1'b1;
		$display("test dynamic ready done");
		// motor strap combinations against command and select
		ready_strap = 1'b0;
		dynamic_card = 1'b0;
		for (int m = 0; m < 6; m++)
		begin
			motor_straps = modes[m];
			for (int k = 0; k < 4; k++)
			begin
				c = 1'(k);
				s = 1'(k >> 1);
				case (m)
					0: {exp_sp, exp_st} = {c, s};
					1: {exp_sp, exp_st} = {c, c};
					2: {exp_sp, exp_st} = {s, s};
					3: {exp_sp, exp_st} = {c, 1'b1};
					4: {exp_sp, exp_st} = {s, 1'b1};
					default: {exp_sp, exp_st} = 2'b00;
				endcase
				go(s ? 3'h0 : 3'h4, c);
				check(spindle_on, exp_sp, "spindle by straps");
				check(stepper_on, exp_st, "stepper by straps");
			end
		end
		$display("test motor straps done");
		complete_run();
	end
endmodule
